/* dual_timer.sv */
// Purpose: two counter/timers with 13-bit, 16-bit, reload and split modes
// Assumes: pins synchronous-sampled here; register port reads answer next cycle
// Notes: Notes on behaviour list below
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns

module dual_timer (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST,
   // register port
   input wire timer_pkg::bus_req_t BUS,
   output logic [7:0] READ_DATA,
   // pins and interrupt acknowledge
   input wire timer_pkg::pins_t PINS,
   input wire logic [1:0] IRQ_ACK,
   // interrupt and overflow outputs
   output logic TIMER0_IRQ,
   output logic TIMER1_IRQ,
   output logic TIMER1_OVERFLOW
);
   import timer_pkg::*;

   state_t st_reg;
   state_t st_next;
   tmode_t mode0;
   tmode_t mode1;
   logic [1:0] fall;
   logic [1:0] gate_ok;
   logic ext_tick;
   logic pre_tick;
   logic split;
   logic go0;
   logic go0_high;
   logic go1;
   logic high0_wrap;
   logic timer1_evt;
   logic [16:0] step0;
   logic [16:0] step1;
   logic [1:0] set_flag;

   // one count step: {overflow, high, low}
   function automatic logic [16:0] step_count(input tmode_t m, input logic [7:0] lo,
                                              input logic [7:0] hi);
      logic [12:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      c13 = {hi, lo[4:0]} + 13'h0001;
      c16 = {1'b0, hi, lo} + 17'h0_0001;
      c8 = {1'b0, lo} + 9'h001;
      step_count = {1'b0, hi, lo};
      unique case (m)
         MODE_13BIT: step_count = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
         MODE_16BIT: step_count = c16;
         MODE_RELOAD: step_count = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
         MODE_SPLIT: step_count = {c8[8], hi, c8[7:0]};
      endcase
   endfunction : step_count

   // clock source for one timer
   function automatic logic source_tick(input logic cnt_sel, input logic sys_sel,
                                        input logic pin_fall, input logic pre);
      source_tick = cnt_sel ? pin_fall : (sys_sel | pre);
   endfunction : source_tick

   // synchronised edges and gates
   assign fall = st_reg.cp3 & ~st_reg.cp2;
   assign gate_ok[0] = ~st_reg.mode[MODE_TIMER0_GATE_SELECT] | (st_reg.ir2[0] == st_reg.pol[0]);
   assign gate_ok[1] = ~st_reg.mode[MODE_TIMER1_GATE_SELECT] | (st_reg.ir2[1] == st_reg.pol[1]);
   assign ext_tick = st_reg.ec2 & ~st_reg.ec3 & (st_reg.ext8 == EXT8_LAST);

   // prescaled clock select
   always_comb begin
      if (st_reg.clk[CLK_SCALE_HI:CLK_SCALE_LO] == SCALE_DIV12) begin
         pre_tick = (st_reg.pre12 == PRE12_LAST);
      end else if (st_reg.clk[CLK_SCALE_HI:CLK_SCALE_LO] == SCALE_EXT8) begin
         pre_tick = ext_tick;
      end else begin
         pre_tick = (st_reg.pre4 == PRE4_LAST);
      end
   end

   // mode decode and count enables
   assign mode0 = tmode_t'(st_reg.mode[MODE_SEL0_HI:MODE_SEL0_LO]);
   assign mode1 = tmode_t'(st_reg.mode[MODE_SEL1_HI:MODE_SEL1_LO]);
   assign split = (mode0 == MODE_SPLIT);
   assign go0 = st_reg.run[0] & gate_ok[0]
      & source_tick(st_reg.mode[MODE_CNT0], st_reg.clk[CLK_SYS0], fall[0], pre_tick);
   assign go0_high = split & st_reg.run[1] & (st_reg.clk[CLK_SYS0] | pre_tick);
   assign high0_wrap = go0_high & (st_reg.high[0] == 8'hFF);
   assign go1 = (mode1 != MODE_SPLIT)
      & (split | (st_reg.run[1] & gate_ok[1]))
      & source_tick(~split & st_reg.mode[MODE_CNT1], st_reg.clk[CLK_SYS1], fall[1],
                    pre_tick);
   assign step0 = step_count(mode0, st_reg.low[0], st_reg.high[0]);
   assign step1 = step_count(mode1, st_reg.low[1], st_reg.high[1]);
   assign timer1_evt = go1 & step1[16];
   assign set_flag[0] = go0 & step0[16];
   assign set_flag[1] = split ? high0_wrap : timer1_evt;

   // next state
   always_comb begin
      st_next = st_reg;
      // input synchronisers and edge history
      st_next.cp1 = PINS.count_pin;
      st_next.cp2 = st_reg.cp1;
      st_next.cp3 = st_reg.cp2;
      st_next.ir1 = PINS.irq_pin;
      st_next.ir2 = st_reg.ir1;
      st_next.ec1 = PINS.ext_clk;
      st_next.ec2 = st_reg.ec1;
      st_next.ec3 = st_reg.ec2;
      // prescalers
      st_next.pre12 = (st_reg.pre12 == PRE12_LAST) ? 4'h0 : st_reg.pre12 + 4'h1;
      st_next.pre4 = st_reg.pre4 + 2'h1;
      if (st_reg.ec2 & ~st_reg.ec3) begin
         st_next.ext8 = st_reg.ext8 + 3'h1;
      end
      // counting
      if (go0) begin
         st_next.low[0] = step0[7:0];
         if (!split) begin
            st_next.high[0] = step0[15:8];
         end
      end
      if (go0_high) begin
         st_next.high[0] = st_reg.high[0] + 8'h01;
      end
      if (go1) begin
         st_next.low[1] = step1[7:0];
         st_next.high[1] = step1[15:8];
      end
      // flags: hardware set wins over any clear
      for (int i = 0; i < 2; i++) begin
         st_next.ovf[i] = set_flag[i] | (st_reg.ovf[i] & ~IRQ_ACK[i]);
      end
      // register writes; count writes win over counting
      if (BUS.wr) begin
         unique case (BUS.addr)
            ADDR_T0_LOW: st_next.low[0] = BUS.wdata;
            ADDR_T0_HIGH: st_next.high[0] = BUS.wdata;
            ADDR_T1_LOW: st_next.low[1] = BUS.wdata;
            ADDR_T1_HIGH: st_next.high[1] = BUS.wdata;
            ADDR_CONTROL: begin
               st_next.run[0] = BUS.wdata[CTRL_RUN0];
               st_next.run[1] = BUS.wdata[CTRL_RUN1];
               st_next.ovf[0] = set_flag[0] | BUS.wdata[CTRL_OVF0];
               st_next.ovf[1] = set_flag[1] | BUS.wdata[CTRL_OVF1];
            end
            ADDR_MODE: st_next.mode = BUS.wdata;
            ADDR_CLOCK: st_next.clk = BUS.wdata[3:0];
            ADDR_IRQ_CFG: st_next.pol = {BUS.wdata[CFG_POL1], BUS.wdata[CFG_POL0]};
            ADDR_IRQ_EN: st_next.irq_en = {BUS.wdata[IRQEN_T1], BUS.wdata[IRQEN_T0]};
            default: st_next.mode = st_reg.mode;
         endcase
      end
      // read data stands one cycle only
      st_next.rdata = 8'h00;
      if (BUS.rd) begin
         unique case (BUS.addr)
            ADDR_T0_LOW: st_next.rdata = st_reg.low[0];
            ADDR_T0_HIGH: st_next.rdata = st_reg.high[0];
            ADDR_T1_LOW: st_next.rdata = st_reg.low[1];
            ADDR_T1_HIGH: st_next.rdata = st_reg.high[1];
            ADDR_CONTROL: begin
               st_next.rdata[CTRL_OVF1] = st_reg.ovf[1];
               st_next.rdata[CTRL_RUN1] = st_reg.run[1];
               st_next.rdata[CTRL_OVF0] = st_reg.ovf[0];
               st_next.rdata[CTRL_RUN0] = st_reg.run[0];
            end
            ADDR_MODE: st_next.rdata = st_reg.mode;
            ADDR_CLOCK: st_next.rdata = {4'h0, st_reg.clk};
            ADDR_IRQ_CFG: begin
               st_next.rdata[CFG_POL0] = st_reg.pol[0];
               st_next.rdata[CFG_POL1] = st_reg.pol[1];
            end
            ADDR_IRQ_EN: begin
               st_next.rdata[IRQEN_T0] = st_reg.irq_en[0];
               st_next.rdata[IRQEN_T1] = st_reg.irq_en[1];
            end
            default: st_next.rdata = 8'h00;
         endcase
      end
      // outputs aligned with the flag registers
      st_next.irq = st_next.ovf & st_next.irq_en;
      st_next.timer1_wrap = timer1_evt;
   end

   // state register
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         st_reg <= STATE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flip-flops
   assign READ_DATA = st_reg.rdata;
   assign TIMER0_IRQ = st_reg.irq[0];
   assign TIMER1_IRQ = st_reg.irq[1];
   assign TIMER1_OVERFLOW = st_reg.timer1_wrap;

   // held timer keeps its count
   property p_hold;
      @(posedge CLOCK) disable iff (RST)
      !st_reg.run[0] && !BUS.wr |=> st_reg.low[0] == $past(st_reg.low[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("timer 0 moved while held");

   // enabling does not touch the count
   property p_run_keep;
      @(posedge CLOCK) disable iff (RST)
      $rose(st_reg.run[0]) && !$past(BUS.wr, 2)
      |-> st_reg.high[0] == $past(st_reg.high[0]);
   endproperty
   a_run_keep: assert property (p_run_keep) else $error("run changed count");

   // 13-bit wrap
   property p_wrap13;
      @(posedge CLOCK) disable iff (RST)
      go0 && mode0 == MODE_13BIT && st_reg.high[0] == 8'hFF && st_reg.low[0][4:0] == 5'h1F
      && !BUS.wr |=> st_reg.ovf[0] && st_reg.high[0] == 8'h00 && st_reg.low[0][4:0] == 5'h00;
   endproperty
   a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong");

   // 16-bit wrap
   property p_wrap16;
      @(posedge CLOCK) disable iff (RST)
      go0 && mode0 == MODE_16BIT && {st_reg.high[0], st_reg.low[0]} == 16'hFFFF && !BUS.wr
      |=> st_reg.ovf[0] && {st_reg.high[0], st_reg.low[0]} == 16'h0000;
   endproperty
   a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong");

   // reload from high byte
   property p_reload;
      @(posedge CLOCK) disable iff (RST)
      go0 && mode0 == MODE_RELOAD && st_reg.low[0] == 8'hFF && !BUS.wr
      |=> st_reg.ovf[0] && st_reg.low[0] == $past(st_reg.high[0])
      && st_reg.high[0] == $past(st_reg.high[0]);
   endproperty
   a_reload: assert property (p_reload) else $error("reload wrong");

   // split high byte drives timer 1 flag and irq
   property p_split_flag;
      @(posedge CLOCK) disable iff (RST)
      high0_wrap && st_reg.irq_en[1] |=> st_reg.ovf[1] && TIMER1_IRQ;
   endproperty
   a_split_flag: assert property (p_split_flag) else $error("split flag missing");

   // timer 1 overflow in split mode leaves its flag alone
   property p_split_quiet;
      @(posedge CLOCK) disable iff (RST)
      split && timer1_evt && !high0_wrap && !st_reg.ovf[1] && !BUS.wr
      |=> !st_reg.ovf[1] && TIMER1_OVERFLOW;
   endproperty
   a_split_quiet: assert property (p_split_quiet) else $error("timer 1 set flag in split");

   // interrupt output follows flag and enable
   property p_irq;
      @(posedge CLOCK) disable iff (RST)
      TIMER0_IRQ == (st_reg.ovf[0] && st_reg.irq_en[0]);
   endproperty
   a_irq: assert property (p_irq) else $error("timer 0 irq mismatch");

   // acknowledge clears unless a new overflow arrives
   property p_ack;
      @(posedge CLOCK) disable iff (RST)
      IRQ_ACK[0] && !set_flag[0] && !BUS.wr |=> !st_reg.ovf[0];
   endproperty
   a_ack: assert property (p_ack) else $error("ack did not clear flag");

   // pin falling edge counts after synchronisation
   property p_pin;
      @(posedge CLOCK) disable iff (RST)
      fall[0] && st_reg.mode[MODE_CNT0] && st_reg.run[0] && gate_ok[0]
      && mode0 == MODE_16BIT && !BUS.wr
      |=> st_reg.low[0] == 8'($past(st_reg.low[0]) + 8'h01);
   endproperty
   a_pin: assert property (p_pin) else $error("pin edge not counted");

   // timer 1 held while stopped outside split
   property p_hold1;
      @(posedge CLOCK) disable iff (RST)
      !split && !st_reg.run[1] && !BUS.wr |=> st_reg.low[1] == $past(st_reg.low[1]);
   endproperty
   a_hold1: assert property (p_hold1) else $error("timer 1 moved while held");

   // closed gate holds timer 0 even with run set
   property p_gate;
      @(posedge CLOCK) disable iff (RST)
      st_reg.run[0] && !gate_ok[0] && !BUS.wr |=> st_reg.low[0] == $past(st_reg.low[0]);
   endproperty
   a_gate: assert property (p_gate) else $error("timer 0 counted with gate shut");

   // split high byte counts one per system or prescaler tick
   property p_split_high;
      @(posedge CLOCK) disable iff (RST)
      go0_high && !BUS.wr |=> st_reg.high[0] == 8'($past(st_reg.high[0]) + 8'h01);
   endproperty
   a_split_high: assert property (p_split_high) else $error("split high missed tick");

   // timer 1 set to mode 3 beside split timer 0 stays put
   property p_split_stop;
      @(posedge CLOCK) disable iff (RST)
      split && mode1 == MODE_SPLIT && !BUS.wr |=> st_reg.low[1] == $past(st_reg.low[1]);
   endproperty
   a_split_stop: assert property (p_split_stop) else $error("timer 1 ran in mode 3");

   // read data returns to zero without a read strobe
   property p_rdata_idle;
      @(posedge CLOCK) disable iff (RST)
      !BUS.rd |=> READ_DATA == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood too long");

   // flag stays set until acknowledged or written
   property p_flag_keep;
      @(posedge CLOCK) disable iff (RST)
      st_reg.ovf[1] && !IRQ_ACK[1] && !BUS.wr |=> st_reg.ovf[1];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("timer 1 flag dropped");

endmodule : dual_timer

/* dual_timer_counter_modes_test.sv */
// Purpose: self-checking bench for the dual counter/timer block
// Assumes: register port answers reads one cycle later, never waits
// Notes: reads queue their expected byte, a monitor compares on arrival
`timescale 1ns/1ns

module dual_timer_counter_modes_test;
   import timer_pkg::*;

   logic clock = 1'b0;
   logic rst = 1'b1;
   bus_req_t bus = '0;
   logic [1:0] count_pin = 2'b11;
   logic [1:0] irq_pin = 2'b00;
   logic [1:0] irq_ack = 2'b00;
   logic [3:0] ext_div = 4'h0;
   pins_t pins;
   logic [7:0] read_data;
   logic timer0_irq;
   logic timer1_irq;
   logic timer1_overflow;
   logic [1:0] irqs;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   int n_fail = 0;
   int samples_checked = 0;
   int ovf_pulses = 0;
   logic [7:0] hi_tab [3] = '{8'hFF, 8'hFF, 8'h80};
   logic [7:0] lo_exp [3] = '{8'hE4, 8'h04, 8'h84};
   logic [7:0] hi_exp [3] = '{8'h00, 8'h00, 8'h80};
   logic [7:0] scale_exp [4] = '{8'h0A, 8'h1E, 8'h1E, 8'h08};

   // pins: external clock is a divided free-running count, period 8 cycles
   assign pins = {count_pin, irq_pin, ext_div[2]};
   assign irqs = {timer1_irq, timer0_irq};

   dual_timer dual_timer_i (
      .CLOCK(clock), .RST(rst), .BUS(bus), .READ_DATA(read_data), .PINS(pins),
      .IRQ_ACK(irq_ack), .TIMER0_IRQ(timer0_irq), .TIMER1_IRQ(timer1_irq),
      .TIMER1_OVERFLOW(timer1_overflow));

   // clock and external clock source
   always #5 clock = ~clock;
   always @(posedge clock) ext_div <= ext_div + 4'h1;

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic conclude;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   // bus tasks: wr and rd take exactly one edge, idle takes n
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clock);
         bus <= '0;
      end
   endtask : idle

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      exp_q.push_back(e);
   endtask : rd

   task automatic pins_set(input logic [1:0] cp, input logic [1:0] ip, input logic [1:0] ack);
      @(posedge clock);
      bus <= '0;
      count_pin <= cp;
      irq_pin <= ip;
      irq_ack <= ack;
   endtask : pins_set

   // run for exactly n counting edges, look at control just before stopping
   task automatic window(input logic [7:0] on, input int n, input logic [7:0] ctrl_exp);
      wr(ADDR_CONTROL, on);
      idle(n - 2);
      rd(ADDR_CONTROL, ctrl_exp);
      wr(ADDR_CONTROL, 8'h00);
      idle(1);
   endtask : window

   task automatic expect_count(input int t, input logic [7:0] lo, input logic [7:0] hi);
      rd(4'(2 * t), lo);
      rd(4'(2 * t + 1), hi);
   endtask : expect_count

   // monitor: read data lands one cycle after the strobe, else zero
   always @(posedge clock) begin
      if (rd_pend && exp_q.size() > 0) begin
         check("read_data", read_data, exp_q.pop_front());
      end else if (!rst) begin
         check("read_idle", read_data, 8'h00);
      end
      rd_pend <= bus.rd && !rst;
      if (timer1_overflow === 1'b1) ovf_pulses++;
   end

   // watchdog against a hung run
   initial begin
      #200000;
      n_fail++;
      conclude();
   end

   // main sequence
   initial begin
      logic [7:0] r;
      int base;
      void'($urandom(17279));
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
      rd(4'hF, 8'h00);
      for (int a = 0; a < 4; a++) begin
         r = 8'($urandom);
         wr(4'(a), r);
         rd(4'(a), r);
      end
      r = 8'($urandom);
      wr(ADDR_MODE, r);
      rd(ADDR_MODE, r);
      wr(ADDR_CLOCK, r);
      rd(ADDR_CLOCK, r & 8'h0F);
      wr(ADDR_IRQ_CFG, r);
      rd(ADDR_IRQ_CFG, r & 8'h03);
      wr(ADDR_IRQ_EN, r);
      rd(ADDR_IRQ_EN, r & 8'h0A);
      wr(ADDR_CONTROL, 8'h0F);
      rd(ADDR_CONTROL, 8'h00);
      wr(ADDR_CLOCK, 8'h0C);
      wr(ADDR_IRQ_CFG, 8'h00);
      wr(ADDR_IRQ_EN, 8'h00);
      // modes 0..2 on each timer, wrap inside the window
      for (int t = 0; t < 2; t++) begin
         for (int m = 0; m < 3; m++) begin
            wr(ADDR_MODE, 8'(m << (4 * t)));
            wr(4'(2 * t + 1), hi_tab[m]);
            wr(4'(2 * t), 8'hFE);
            window(8'(8'h10 << (2 * t)), 6, 8'(8'h30 << (2 * t)));
            expect_count(t, lo_exp[m], hi_exp[m]);
         end
      end
      rd(ADDR_CONTROL, 8'h00);
      // flags: masked, enabled, cleared by acknowledge
      for (int t = 0; t < 2; t++) begin
         wr(ADDR_IRQ_EN, 8'h00);
         wr(ADDR_CONTROL, 8'(8'h20 << (2 * t)));
         idle(2);
         check("irq_masked", {7'h00, irqs[t]}, 8'h00);
         wr(ADDR_IRQ_EN, 8'(8'h02 << (2 * t)));
         idle(2);
         check("irq_enabled", {7'h00, irqs[t]}, 8'h01);
         pins_set(2'b11, 2'b00, 2'(1 << t));
         pins_set(2'b11, 2'b00, 2'b00);
         idle(2);
         check("irq_acked", {7'h00, irqs[t]}, 8'h00);
         rd(ADDR_CONTROL, 8'h00);
      end
      // prescaler settings, window a whole number of ticks long
      wr(ADDR_MODE, 8'h01);
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_CLOCK, 8'(s));
         wr(ADDR_T0_LOW, 8'h00);
         wr(ADDR_T0_HIGH, 8'h00);
         window(8'h10, (s == 3) ? 512 : 120, 8'h10);
         expect_count(0, scale_exp[s], 8'h00);
      end
      // gate: held while inactive, counts while active at either polarity
      wr(ADDR_CLOCK, 8'h04);
      wr(ADDR_MODE, 8'h09);
      wr(ADDR_IRQ_CFG, 8'h01);
      wr(ADDR_T0_LOW, 8'h00);
      window(8'h10, 20, 8'h10);
      expect_count(0, 8'h00, 8'h00);
      pins_set(2'b11, 2'b01, 2'b00);
      idle(4);
      window(8'h10, 20, 8'h10);
      expect_count(0, 8'h14, 8'h00);
      wr(ADDR_IRQ_CFG, 8'h00);
      idle(4);
      window(8'h10, 20, 8'h10);
      expect_count(0, 8'h14, 8'h00);
      pins_set(2'b11, 2'b00, 2'b00);
      idle(4);
      window(8'h10, 20, 8'h10);
      expect_count(0, 8'h28, 8'h00);
      // counter pins: three falling edges on each timer
      wr(ADDR_MODE, 8'h55);
      for (int a = 0; a < 4; a++) wr(4'(a), 8'h00);
      wr(ADDR_CONTROL, 8'h50);
      repeat (3) begin
         pins_set(2'b00, 2'b01, 2'b00);
         idle(3);
         pins_set(2'b11, 2'b01, 2'b00);
         idle(3);
      end
      idle(6);
      wr(ADDR_CONTROL, 8'h00);
      expect_count(0, 8'h03, 8'h00);
      expect_count(1, 8'h03, 8'h00);
      // split mode: high byte on timer 1 run, timer 1 free and flagless
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_CLOCK, 8'h0C);
      wr(ADDR_IRQ_EN, 8'h0A);
      wr(ADDR_T1_LOW, 8'h1F);
      wr(ADDR_T1_HIGH, 8'hFF);
      wr(ADDR_T0_LOW, 8'h55);
      wr(ADDR_T0_HIGH, 8'h10);
      base = ovf_pulses;
      wr(ADDR_MODE, 8'h03);
      idle(4);
      rd(ADDR_CONTROL, 8'h00);
      window(8'h40, 244, 8'hC0);
      expect_count(0, 8'h55, 8'h04);
      idle(2);
      check("overflow_pulses", 8'(ovf_pulses - base), 8'h01);
      wr(ADDR_MODE, 8'h33);
      wr(ADDR_T1_LOW, 8'h00);
      wr(ADDR_T1_HIGH, 8'h00);
      idle(10);
      expect_count(1, 8'h00, 8'h00);
      idle(3);
      conclude();
   end

endmodule : dual_timer_counter_modes_test

/* timer_pkg.sv */
// Purpose: constants and carrier types for the dual counter/timer block
// Assumes: 8-bit register port, one clock, offsets below are block-local
// Notes: field positions follow the control, mode and clock registers
package timer_pkg;

   // register offsets on the plain register port
   localparam logic [3:0] ADDR_T0_LOW = 4'h0;
   localparam logic [3:0] ADDR_T0_HIGH = 4'h1;
   localparam logic [3:0] ADDR_T1_LOW = 4'h2;
   localparam logic [3:0] ADDR_T1_HIGH = 4'h3;
   localparam logic [3:0] ADDR_CONTROL = 4'h4;
   localparam logic [3:0] ADDR_MODE = 4'h5;
   localparam logic [3:0] ADDR_CLOCK = 4'h6;
   localparam logic [3:0] ADDR_IRQ_CFG = 4'h7;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h8;

   // timer_control_reg fields
   localparam int CTRL_OVF1 = 7;
   localparam int CTRL_RUN1 = 6;
   localparam int CTRL_OVF0 = 5;
   localparam int CTRL_RUN0 = 4;

   // timer_mode_reg fields
   localparam int MODE_TIMER1_GATE_SELECT = 7;
   localparam int MODE_CNT1 = 6;
   localparam int MODE_SEL1_HI = 5;
   localparam int MODE_SEL1_LO = 4;
   localparam int MODE_TIMER0_GATE_SELECT = 3;
   localparam int MODE_CNT0 = 2;
   localparam int MODE_SEL0_HI = 1;
   localparam int MODE_SEL0_LO = 0;

   // clock_control_reg fields
   localparam int CLK_SYS1 = 3;
   localparam int CLK_SYS0 = 2;
   localparam int CLK_SCALE_HI = 1;
   localparam int CLK_SCALE_LO = 0;

   // ext_irq_config_reg and interrupt_enable_reg fields
   localparam int CFG_POL0 = 0;
   localparam int CFG_POL1 = 1;
   localparam int IRQEN_T0 = 1;
   localparam int IRQEN_T1 = 3;

   // prescaler settings and terminal counts
   localparam logic [1:0] SCALE_DIV12 = 2'h0;
   localparam logic [1:0] SCALE_EXT8 = 2'h3;
   localparam logic [3:0] PRE12_LAST = 4'hB;
   localparam logic [1:0] PRE4_LAST = 2'h3;
   localparam logic [2:0] EXT8_LAST = 3'h7;

   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } tmode_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic [1:0] count_pin;
      logic [1:0] irq_pin;
      logic ext_clk;
   } pins_t;

   typedef struct packed {
      logic [1:0][7:0] low;
      logic [1:0][7:0] high;
      logic [1:0] run;
      logic [1:0] ovf;
      logic [7:0] mode;
      logic [3:0] clk;
      logic [1:0] pol;
      logic [1:0] irq_en;
      logic [1:0] cp1;
      logic [1:0] cp2;
      logic [1:0] cp3;
      logic [1:0] ir1;
      logic [1:0] ir2;
      logic ec1;
      logic ec2;
      logic ec3;
      logic [3:0] pre12;
      logic [1:0] pre4;
      logic [2:0] ext8;
      logic [1:0] irq;
      logic timer1_wrap;
      logic [7:0] rdata;
   } state_t;

   localparam state_t STATE_RESET = '0;

endpackage : timer_pkg
